// ===== core/smr_ctrl.sv
// controller end: reset, init sequence, mode register writes, keep-alive
// assumes: software drives it over axi4-lite, memory model on the link
// Function
// - issue long calibration after mode writes
// - wait lock and calibration before use
// - refresh within idle limit after init
// - rerun init after supply level change
// - deselect between mode writes and calibration
// - write every defined mode register
// - dll enable written before dll reset
// - hold connectivity test enable low
// - hold reset pulse, cke low first
// - after reset repeat power-on steps
// - reset clears counters except refresh
// - seven mode registers, written by mrs
// - fully write registers before use
// - drive every field on each mrs
// - mode writes leave array untouched
// - re-executed mrs updates contents
// - space mode writes by tmrd
// - special writes wait for completion
// - tmod before non-mode command
// - special timing replaces tmod
// - select bits 20:18, 111 unused
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
module smr_ctrl #(
   parameter int unsigned POST_RST_CYC = smr_pkg::POST_RST_CYC,
   parameter int unsigned KEEPALIVE_CYC = smr_pkg::KEEPALIVE_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // axi4-lite write address
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // status
   output logic init_done,
   // link
   smr_link_if.ctrl link
);
   if (POST_RST_CYC < 1 || POST_RST_CYC > 65535 || KEEPALIVE_CYC < 2) begin : g_chk
      $error("smr_ctrl: wait counts out of range");
   end

   typedef enum logic [3:0] {
      ST_OFF, ST_RST, ST_WAKE, ST_XPR, ST_MRS, ST_ZQ, ST_CAL, ST_RUN
   } smr_state_t;

   typedef struct packed {
      smr_state_t st;
      logic [2:0] mi;
      logic [15:0] cnt;
      logic [15:0] mrd;
      logic [15:0] mod;
      logic [31:0] idle;
      logic reset_n;
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [2:0] sel;
      logic [17:0] addr;
      logic init_req;
      logic mrs_req;
      logic ka_en;
      logic bad_sel;
      logic ready;
      logic [31:0] mrs_data;
      logic [31:0] tim0;
      logic [31:0] tim1;
      logic [31:0] tim2;
      logic [smr_pkg::MR_COUNT-1:0][smr_pkg::MR_W-1:0] mr_tab;
      logic aw_got;
      logic w_got;
      logic [7:0] wa;
      logic [31:0] wd;
      logic [3:0] ws;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } smr_ctrl_t;

   smr_ctrl_t s;
   smr_ctrl_t next_s;

   // byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction

   // mode table address check and index
   function automatic logic is_mr(input logic [7:0] a);
      return a >= smr_pkg::ADDR_MR_BASE && a < smr_pkg::ADDR_MR_BASE + 8'(4 * smr_pkg::MR_COUNT)
             && a[1:0] == 2'h0;
   endfunction

   function automatic logic [2:0] mr_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - smr_pkg::ADDR_MR_BASE;
      return d[4:2];
   endfunction

   function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? a : b;
   endfunction

   // ==========================================
   // next state
   always_comb begin
      logic [31:0] cur;
      logic ok;
      logic [2:0] isel;
      logic long_wait;
      cur = 32'h0;
      ok = 1'b1;
      isel = smr_pkg::INIT_ORDER[s.mi*3 +: 3];
      long_wait = s.mrs_data[smr_pkg::MRS_LONG_BIT];
      next_s = s;
      // deselect every cycle unless a command is issued
      next_s.cs_n = 1'b1;
      next_s.ras_n = 1'b1;
      next_s.cas_n = 1'b1;
      next_s.we_n = 1'b1;
      if (s.cnt != 16'h0)
         next_s.cnt = s.cnt - 16'h1;
      if (s.mrd != 16'h0)
         next_s.mrd = s.mrd - 16'h1;
      if (s.mod != 16'h0)
         next_s.mod = s.mod - 16'h1;
      if (s.idle != 32'hffffffff)
         next_s.idle = s.idle + 32'h1;

      // sequence
      case (s.st)
         ST_OFF: begin
            next_s.reset_n = 1'b0;
            next_s.cke = 1'b0;
            if (s.init_req) begin
               next_s.init_req = 1'b0;
               next_s.ready = 1'b0;
               next_s.cnt = max16(s.tim2[15:0], smr_pkg::CKE_SETUP_CYC);
               next_s.st = ST_RST;
            end
         end
         ST_RST: if (s.cnt == 16'h0) begin
            next_s.reset_n = 1'b1;
            next_s.cnt = s.tim2[31:16];
            next_s.st = ST_WAKE;
         end
         ST_WAKE: if (s.cnt == 16'h0) begin
            next_s.cke = 1'b1;
            next_s.cnt = {8'h0, s.tim0[15:8]};
            next_s.st = ST_XPR;
         end
         ST_XPR: if (s.cnt == 16'h0) begin
            next_s.mi = 3'h0;
            next_s.st = ST_MRS;
         end
         ST_MRS: if (s.mrd == 16'h0) begin
            // fixed order puts mr1 before mr0 and covers all seven
            next_s.cs_n = 1'b0;
            next_s.ras_n = 1'b0;
            next_s.cas_n = 1'b0;
            next_s.we_n = 1'b0;
            next_s.sel = isel;
            next_s.addr = s.mr_tab[isel];
            next_s.mrd = {8'h0, s.tim0[7:0]};
            next_s.mod = {8'h0, s.tim0[15:8]};
            if (s.mi == 3'(smr_pkg::MR_COUNT - 1))
               next_s.st = ST_ZQ;
            else
               next_s.mi = s.mi + 3'h1;
         end
         ST_ZQ: if (s.mrd == 16'h0 && s.mod == 16'h0) begin
            next_s.cs_n = 1'b0;
            next_s.we_n = 1'b0;
            next_s.addr = 18'h0;
            next_s.addr[smr_pkg::ZQ_LONG_BIT] = 1'b1;
            next_s.cnt = max16(s.tim1[15:0], s.tim1[31:16]);
            next_s.st = ST_CAL;
         end
         ST_CAL: if (s.cnt == 16'h0) begin
            next_s.ready = 1'b1;
            next_s.idle = 32'h0;
            next_s.st = ST_RUN;
         end
         ST_RUN: begin
            if (s.init_req) begin
               next_s.ready = 1'b0;
               next_s.st = ST_OFF;
            end else if (s.mrs_req && s.mrd == 16'h0 && s.cs_n) begin
               // cs_n check keeps one deselect after a keep-alive refresh
               next_s.mrs_req = 1'b0;
               if (s.mrs_data[20:18] == smr_pkg::MR_SEL_BAD) begin
                  next_s.bad_sel = 1'b1;
               end else begin
                  next_s.cs_n = 1'b0;
                  next_s.ras_n = 1'b0;
                  next_s.cas_n = 1'b0;
                  next_s.we_n = 1'b0;
                  next_s.sel = s.mrs_data[20:18];
                  next_s.addr = s.mrs_data[17:0];
                  next_s.mrd = long_wait ? s.tim0[31:16] : {8'h0, s.tim0[7:0]};
                  next_s.mod = long_wait ? s.tim0[31:16] : {8'h0, s.tim0[15:8]};
                  next_s.idle = 32'h0;
               end
            end else if (s.ka_en && s.idle >= 32'(KEEPALIVE_CYC - 1)
                         && s.mrd == 16'h0 && s.mod == 16'h0) begin
               next_s.cs_n = 1'b0;
               next_s.ras_n = 1'b0;
               next_s.cas_n = 1'b0;
               next_s.idle = 32'h0;
            end
         end
         default: next_s.st = ST_OFF;
      endcase

      // axi write: address and data in either order
      if (awvalid && s.awready) begin
         next_s.aw_got = 1'b1;
         next_s.wa = awaddr;
      end
      if (wvalid && s.wready) begin
         next_s.w_got = 1'b1;
         next_s.wd = wdata;
         next_s.ws = wstrb;
      end
      if (s.bvalid && bready)
         next_s.bvalid = 1'b0;
      if (s.aw_got && s.w_got) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = smr_pkg::RESP_OKAY;
         // software sets after the sequence clears, so a set is never lost
         case (s.wa)
            smr_pkg::ADDR_CTRL: begin
               cur = merge(32'h0, s.wd, s.ws);
               if (cur[smr_pkg::CTRL_INIT_BIT])
                  next_s.init_req = 1'b1;
               if (cur[smr_pkg::CTRL_MRS_BIT])
                  next_s.mrs_req = 1'b1;
               if (s.ws[0])
                  next_s.ka_en = s.wd[smr_pkg::CTRL_KA_BIT];
            end
            smr_pkg::ADDR_STATUS: ;
            smr_pkg::ADDR_MRS: next_s.mrs_data = merge(s.mrs_data, s.wd, s.ws);
            smr_pkg::ADDR_TIM0: next_s.tim0 = merge(s.tim0, s.wd, s.ws);
            smr_pkg::ADDR_TIM1: next_s.tim1 = merge(s.tim1, s.wd, s.ws);
            smr_pkg::ADDR_TIM2: next_s.tim2 = merge(s.tim2, s.wd, s.ws);
            default: begin
               if (is_mr(s.wa)) begin
                  cur = merge({14'h0, s.mr_tab[mr_idx(s.wa)]}, s.wd, s.ws);
                  next_s.mr_tab[mr_idx(s.wa)] = cur[17:0];
               end else begin
                  next_s.bresp = smr_pkg::RESP_SLVERR;
               end
            end
         endcase
      end
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;

      // axi read
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end
      if (arvalid && s.arready) begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         case (araddr)
            smr_pkg::ADDR_CTRL: cur = {29'h0, s.ka_en, s.mrs_req, s.init_req};
            smr_pkg::ADDR_STATUS: cur = {20'h0, 4'(s.st), 5'h0, s.bad_sel,
                                         s.st != ST_RUN, s.ready};
            smr_pkg::ADDR_MRS: cur = s.mrs_data;
            smr_pkg::ADDR_TIM0: cur = s.tim0;
            smr_pkg::ADDR_TIM1: cur = s.tim1;
            smr_pkg::ADDR_TIM2: cur = s.tim2;
            default: begin
               ok = is_mr(araddr);
               cur = ok ? {14'h0, s.mr_tab[mr_idx(araddr)]} : 32'h0;
            end
         endcase
         next_s.rdata = cur;
         next_s.rresp = ok ? smr_pkg::RESP_OKAY : smr_pkg::RESP_SLVERR;
      end

      // synchronous reset values
      if (rst) begin
         next_s = '0;
         next_s.st = ST_OFF;
         next_s.cs_n = 1'b1;
         next_s.ras_n = 1'b1;
         next_s.cas_n = 1'b1;
         next_s.we_n = 1'b1;
         next_s.ka_en = 1'b1;
         next_s.tim0 = {smr_pkg::TSPEC_RST, smr_pkg::TMOD_RST, smr_pkg::TMRD_RST};
         next_s.tim1 = {smr_pkg::TZQINIT_RST, smr_pkg::TDLLK_RST};
         next_s.tim2 = {16'(POST_RST_CYC), smr_pkg::TPW_RST};
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
         next_s.arready = 1'b1;
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      s <= next_s;
   end

   // outputs straight from the state register, except bg[1] and connectivity_test_enable, which are tied low
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign init_done = s.ready;
   assign link.reset_n = s.reset_n;
   assign link.cke = s.cke;
   assign link.cs_n = s.cs_n;
   assign link.ras_n = s.ras_n;
   assign link.cas_n = s.cas_n;
   assign link.we_n = s.we_n;
   assign link.bg = {1'b0, s.sel[2]};
   assign link.ba = s.sel[1:0];
   assign link.addr = s.addr;
   assign link.connectivity_test_enable = 1'b0;
endmodule
`default_nettype wire

// ===== inc/smr_pkg.sv
// package: shared constants, types and helpers for the init/mode-register link
// assumes: one 40 MHz clock shared by controller and memory model
`default_nettype none
package smr_pkg;
   // ==========================================
   // clock and timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int CKE_SETUP_NS = 10;
   localparam int CKE_SETUP_CYC_I = (CKE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] CKE_SETUP_CYC = 16'(CKE_SETUP_CYC_I);
   localparam int POST_RST_US = 500;
   localparam int POST_RST_CYC = POST_RST_US * 1000 / CLK_PERIOD_NS;
   localparam int IDLE_LIMIT_MS = 960;
   localparam int KEEPALIVE_CYC = IDLE_LIMIT_MS * (1000000 / CLK_PERIOD_NS);
   localparam logic [7:0] TMRD_RST = 8'h08;
   localparam logic [7:0] TMOD_RST = 8'h18;
   localparam logic [15:0] TSPEC_RST = 16'h0100;
   localparam logic [15:0] TDLLK_RST = 16'h0400;
   localparam logic [15:0] TZQINIT_RST = 16'h0400;
   localparam logic [15:0] TPW_RST = 16'h0028;
   localparam int TDLLK_CYC = 1024;
   localparam int TZQINIT_CYC = 1024;

   // ==========================================
   // register offsets (byte addresses)
   localparam int AXI_ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MRS = 8'h08;
   localparam logic [7:0] ADDR_TIM0 = 8'h0c;
   localparam logic [7:0] ADDR_TIM1 = 8'h10;
   localparam logic [7:0] ADDR_TIM2 = 8'h14;
   localparam logic [7:0] ADDR_MR_BASE = 8'h20;

   // ==========================================
   // field positions
   localparam int CTRL_INIT_BIT = 0;
   localparam int CTRL_MRS_BIT = 1;
   localparam int CTRL_KA_BIT = 2;
   localparam int MRS_LONG_BIT = 31;
   localparam int DLL_RESET_BIT = 8;
   localparam int ZQ_LONG_BIT = 10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================
   // mode registers
   localparam int MR_COUNT = 7;
   localparam int MR_W = 18;
   localparam logic [2:0] MR_SEL_BAD = 3'h7;
   // init order, first entry in the low bits: mr3, mr6, mr5, mr4, mr2, mr1, mr0
   localparam logic [20:0] INIT_ORDER = {3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3};

   typedef enum logic [2:0] {CMD_DES, CMD_MRS, CMD_REF, CMD_ZQ, CMD_OTHER} smr_cmd_t;

   // command decode from the control pins
   function automatic smr_cmd_t smr_decode(input logic cs_n, input logic ras_n,
                                           input logic cas_n, input logic we_n);
      if (cs_n)
         return CMD_DES;
      case ({ras_n, cas_n, we_n})
         3'h0: return CMD_MRS;
         3'h1: return CMD_REF;
         3'h6: return CMD_ZQ;
         default: return CMD_OTHER;
      endcase
   endfunction
endpackage
`default_nettype wire

// ===== inc/smr_link_if.sv
// interface: command/address link between controller and memory model
// assumes: both ends clocked by the same core_clk
`default_nettype none
interface smr_link_if;
   logic reset_n;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [1:0] bg;
   logic [1:0] ba;
   logic [17:0] addr;
   logic connectivity_test_enable;
   modport ctrl (output reset_n, cke, cs_n, ras_n, cas_n, we_n, bg, ba, addr,
                 connectivity_test_enable);
   modport dram (input reset_n, cke, cs_n, ras_n, cas_n, we_n, bg, ba, addr,
                 connectivity_test_enable);
endinterface
`default_nettype wire

// ===== core/smr_dram.sv
// memory end: seven mode registers, dll lock and calibration tracking
// assumes: commands sampled on core_clk, controller keeps its own timing
`default_nettype none
module smr_dram #(
   parameter int unsigned DLLK_CYC = smr_pkg::TDLLK_CYC,
   parameter int unsigned ZQINIT_CYC = smr_pkg::TZQINIT_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // link
   smr_link_if.dram link,
   // user side
   input wire logic [2:0] mr_index,
   output logic [17:0] mr_value,
   output logic ready,
   output logic bad_select,
   output logic [15:0] refresh_count
);
   if (DLLK_CYC < 1 || DLLK_CYC > 65535 || ZQINIT_CYC < 1 || ZQINIT_CYC > 65535) begin : g_chk
      $error("smr_dram: lock or calibration count out of range");
   end

   typedef struct packed {
      logic [smr_pkg::MR_COUNT-1:0][smr_pkg::MR_W-1:0] mr;
      logic [15:0] dll_cnt;
      logic [15:0] zq_cnt;
      logic dll_locked;
      logic zq_done;
      logic ready;
      logic bad_select;
      logic [15:0] ref_cnt;
      logic [17:0] mr_value;
   } smr_dram_t;

   smr_dram_t s;
   smr_dram_t next_s;
   smr_pkg::smr_cmd_t cmd;
   logic [2:0] sel;

   assign cmd = smr_pkg::smr_decode(link.cs_n, link.ras_n, link.cas_n, link.we_n);
   assign sel = {link.bg[0], link.ba};

   // ==========================================
   // next state
   always_comb begin
      next_s = s;
      // timers run down, completion raises lock or calibration flags
      if (s.dll_cnt != 16'h0) begin
         next_s.dll_cnt = s.dll_cnt - 16'h1;
         if (s.dll_cnt == 16'h1)
            next_s.dll_locked = 1'b1;
      end
      if (s.zq_cnt != 16'h0) begin
         next_s.zq_cnt = s.zq_cnt - 16'h1;
         if (s.zq_cnt == 16'h1)
            next_s.zq_done = 1'b1;
      end
      if (rst) begin
         next_s = '0;
      end else if (!link.reset_n) begin
         // reset clears every counter but the refresh one
         next_s.dll_cnt = 16'h0;
         next_s.zq_cnt = 16'h0;
         next_s.dll_locked = 1'b0;
         next_s.zq_done = 1'b0;
      end else if (link.cke && !link.connectivity_test_enable) begin
         case (cmd)
            smr_pkg::CMD_MRS: begin
               // accepted any time, no array effect, re-writes take effect
               if (sel == smr_pkg::MR_SEL_BAD) begin
                  next_s.bad_select = 1'b1;
               end else begin
                  next_s.mr[sel] = link.addr;
                  if (sel == 3'h0 && link.addr[smr_pkg::DLL_RESET_BIT]) begin
                     next_s.dll_cnt = 16'(DLLK_CYC);
                     next_s.dll_locked = 1'b0;
                  end
               end
            end
            smr_pkg::CMD_ZQ: begin
               if (link.addr[smr_pkg::ZQ_LONG_BIT]) begin
                  next_s.zq_cnt = 16'(ZQINIT_CYC);
                  next_s.zq_done = 1'b0;
               end
            end
            smr_pkg::CMD_REF: next_s.ref_cnt = s.ref_cnt + 16'h1;
            default: ;
         endcase
      end
      // ready only once lock and calibration both completed
      next_s.ready = next_s.dll_locked && next_s.zq_done;
      next_s.mr_value = (mr_index < 3'(smr_pkg::MR_COUNT)) ? next_s.mr[mr_index] : 18'h0;
   end

   // state register
   always_ff @(posedge core_clk) begin
      s <= next_s;
   end

   assign mr_value = s.mr_value;
   assign ready = s.ready;
   assign bad_select = s.bad_select;
   assign refresh_count = s.ref_cnt;
endmodule
`default_nettype wire

// ===== tb/smr_link_props.sv
// checker: command timing and pin rules on the controller-to-memory link
// assumes: instantiated beside the link interface, single core_clk domain
`default_nettype none
module smr_link_props (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // link pins
   input wire logic reset_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] bg,
   input wire logic [1:0] ba,
   input wire logic [17:0] addr,
   input wire logic connectivity_test_enable,
   // status of both ends
   input wire logic init_done,
   input wire logic ready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic mrs;
   logic zq;
   logic [5:0] since_mrs;
   // command decode
   assign mrs = !cs_n && !ras_n && !cas_n && !we_n;
   assign zq = !cs_n && ras_n && cas_n && !we_n;
   // cycles since last mode write, saturating
   always_ff @(posedge core_clk) begin
      if (rst) begin
         since_mrs <= 6'h3f;
      end else if (mrs) begin
         since_mrs <= 6'h01;
      end else if (since_mrs != 6'h3f) begin
         since_mrs <= since_mrs + 6'h01;
      end
   end
   property p_test_low; connectivity_test_enable == 1'b0; endproperty
   property p_cke_first; $rose(reset_n) |-> !cke && $past(cke) == 1'b0; endproperty
   property p_rst_pulse; $fell(reset_n) |-> !reset_n [*8]; endproperty
   property p_mrd; mrs |=> !mrs [*7]; endproperty
   property p_mod; (!cs_n && !mrs) |-> since_mrs >= 6'h18; endproperty
   property p_zq_long; zq |-> addr[10]; endproperty
   property p_one_cycle; !cs_n |=> cs_n; endproperty
   property p_sel; mrs |-> !bg[1] && {bg[0], ba} != 3'h7; endproperty
   property p_ready_wait; zq |=> !ready [*7]; endproperty
   property p_done_wait; zq |=> !init_done [*7]; endproperty
   a_test_low: assert property (p_test_low) else $error("test enable high");
   a_cke_first: assert property (p_cke_first) else $error("cke high at reset end");
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse short");
   a_mrd: assert property (p_mrd) else $error("mode writes too close");
   a_mod: assert property (p_mod) else $error("command too soon after mode write");
   a_zq_long: assert property (p_zq_long) else $error("calibration not long");
   a_one_cycle: assert property (p_one_cycle) else $error("no deselect after command");
   a_sel: assert property (p_sel) else $error("bad register select sent");
   a_ready_wait: assert property (p_ready_wait) else $error("ready too early");
   a_done_wait: assert property (p_done_wait) else $error("init done too early");
   c_mrs: cover property (mrs);
   c_zq: cover property (zq);
   c_ref: cover property (!cs_n && !ras_n && !cas_n && we_n);
endmodule
`default_nettype wire

// ===== tb/tb.sv
// testbench: controller and memory joined by the link, driven over axi4-lite
// assumes: shortened post-reset, keep-alive and lock counts
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, init_done, ready, bad_select;
   logic [1:0] bresp, rresp, r;
   logic [2:0] mr_index = 3'h0;
   logic [17:0] mr_value, m;
   logic [15:0] refresh_count, rc;
   int mismatches = 0, samples_checked = 0, cycles = 0;
   smr_link_if link();
   smr_ctrl #(.POST_RST_CYC(20), .KEEPALIVE_CYC(50)) smr_ctrl_inst (.core_clk(core_clk),
      .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .init_done(init_done), .link(link));
   smr_dram #(.DLLK_CYC(8), .ZQINIT_CYC(8)) smr_dram_inst (.core_clk(core_clk), .rst(rst),
      .link(link), .mr_index(mr_index), .mr_value(mr_value), .ready(ready),
      .bad_select(bad_select), .refresh_count(refresh_count));
   smr_link_props smr_link_props_inst (.core_clk(core_clk), .rst(rst),
      .reset_n(link.reset_n), .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
      .cas_n(link.cas_n), .we_n(link.we_n), .bg(link.bg), .ba(link.ba), .addr(link.addr),
      .connectivity_test_enable(link.connectivity_test_enable), .init_done(init_done),
      .ready(ready));
   // ==========================================
   // clock and watchdog
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   // ==========================================
   // tasks
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one axi write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   // one axi read
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // memory-side mode register peek
   task automatic peek(input logic [2:0] i);
      @(posedge core_clk);
      mr_index <= i;
      repeat (2) @(posedge core_clk);
      m = mr_value;
   endtask
   // start init and wait for run state
   task automatic do_init();
      wr(smr_pkg::ADDR_CTRL, 32'h00000005);
      for (int k = 0; k < 10 && init_done === 1'b1; k++) @(posedge core_clk);
      while (init_done !== 1'b1) @(posedge core_clk);
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rd(smr_pkg::ADDR_TIM0);
      check("tim0", v, 32'h01001808);
      rd(smr_pkg::ADDR_TIM2);
      check("tim2", v, 32'h00140028);
      rd(smr_pkg::ADDR_CTRL);
      check("ctrl", v, 32'h00000004);
      rd(8'h18);
      check("unmapped read", {v[29:0], r}, {30'h0, smr_pkg::RESP_SLVERR});
      wr(8'h18, 32'h1);
      check("unmapped write", 32'(r), 32'(smr_pkg::RESP_SLVERR));
      wr(smr_pkg::ADDR_TIM1, 32'h00080008);
      rd(smr_pkg::ADDR_TIM1);
      check("tim1", v, 32'h00080008);
      for (int i = 0; i < 7; i++) wr(smr_pkg::ADDR_MR_BASE + 8'(4 * i), 32'h101 | (i << 12));
      do_init();
      check("ready", 32'(ready), 32'h1);
      for (int i = 0; i < 7; i++) begin
         peek(3'(i));
         check("mode reg", 32'(m), 32'h101 | (i << 12));
      end
      wr(smr_pkg::ADDR_MRS, 32'h0008aaaa);
      wr(smr_pkg::ADDR_CTRL, 32'h00000006);
      for (int k = 0; k < 40 && m !== 18'h0aaaa; k++) peek(3'h2);
      check("rewrite", 32'(m), 32'h0aaaa);
      wr(smr_pkg::ADDR_MRS, 32'h001c0001);
      wr(smr_pkg::ADDR_CTRL, 32'h00000006);
      rd(smr_pkg::ADDR_STATUS);
      check("refused select", {v[2], bad_select}, 32'h2);
      // special write holds the next one back for the long wait
      wr(smr_pkg::ADDR_MRS, 32'h80040003);
      wr(smr_pkg::ADDR_CTRL, 32'h00000006);
      wr(smr_pkg::ADDR_MRS, 32'h00040005);
      wr(smr_pkg::ADDR_CTRL, 32'h00000006);
      repeat (200) @(posedge core_clk);
      peek(3'h1);
      check("special wait held", 32'(m), 32'h3);
      repeat (80) @(posedge core_clk);
      peek(3'h1);
      check("special wait over", 32'(m), 32'h5);
      for (int k = 0; k < 300 && refresh_count === 16'h0; k++) @(posedge core_clk);
      rc = refresh_count;
      check("keep-alive", 32'(rc != 16'h0), 32'h1);
      do_init();
      check("refresh kept", 32'(refresh_count >= rc), 32'h1);
      peek(3'h2);
      check("mode reg again", 32'(m), 32'h2101);
      check("ready again", 32'(ready), 32'h1);
      report_and_stop();
   end
endmodule
`default_nettype wire
